// file: pkg/srcs_pkg.sv
package srcs_pkg;
    // Sequencer lengths in oscillator cycles, bus divider and counter widths
    localparam int SRCS_POR_CYCLES = 4096;
    localparam int SRCS_DRIVE_CYCLES = 32;
    localparam int SRCS_HOLD_CYCLES = 32;
    localparam int SRCS_PIN_MIN_CYCLES = 67;
    localparam int SRCS_PIN_POR_CYCLES = 4163;
    localparam int SRCS_BUS_DIV = 4;
    localparam int SRCS_SYS_BITS = 13;
    localparam int SRCS_SVC_LSB = 4;
    localparam int SRCS_SEQ_BITS = 13;
    // Vectors and addresses
    localparam logic [15:0] SRCS_VEC_NORMAL = 16'hFFFE;
    localparam logic [15:0] SRCS_VEC_MONITOR = 16'hFEFE;
    localparam logic [15:0] SRCS_SVC_ADDR = 16'hFFFF;
    localparam logic [15:0] SRCS_VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] SRCS_VEC_LO_ADDR = 16'hFFFF;
    localparam logic [7:0] SRCS_ERASED = 8'hFF;
    // Register byte offsets
    localparam logic [7:0] SRCS_OFS_CAUSE = 8'h00;
    localparam logic [7:0] SRCS_OFS_CTRL = 8'h04;
    localparam logic [7:0] SRCS_OFS_STATUS = 8'h08;
    // Cause flag positions and register reset values
    localparam int SRCS_F_POR = 7;
    localparam int SRCS_F_PIN = 6;
    localparam int SRCS_F_WDOG = 5;
    localparam int SRCS_F_BADOP = 4;
    localparam int SRCS_F_BADADR = 3;
    localparam int SRCS_F_MENTRY = 2;
    localparam int SRCS_F_LVD = 1;
    localparam logic [7:0] SRCS_CAUSE_RST = 8'h80;
    localparam logic [7:0] SRCS_CTRL_RST = 8'h00;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_POR = 3'b001,
        ST_DRIVE = 3'b010,
        ST_HOLD = 3'b011,
        ST_EXT = 3'b100
    } srcs_state_t;
endpackage

// file: pkg/srcs_link_if.sv
`timescale 1ns/1ps
interface srcs_link_if;
    logic clear_all;
    logic service;
    logic wdog_en;
    logic wdog_ovf;
    logic [12:0] sys_count;
    logic src_edge;
    logic run;
    logic bus_clk;
    modport cnt (input clear_all, service, wdog_en,
                 output wdog_ovf, sys_count);
    modport clk (input src_edge, run, output bus_clk);
    modport ctl (output clear_all, service, wdog_en, src_edge, run,
                 input wdog_ovf, sys_count, bus_clk);
endinterface

// file: src/srcs_counter.sv
`timescale 1ns/1ps
module srcs_counter
    import srcs_pkg::*;
#(
    parameter int WDOG_BITS = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    srcs_link_if.cnt lnk
);
    initial begin
        if (WDOG_BITS < 1 || WDOG_BITS > 16) begin
            $error("WDOG_BITS out of range");
        end
    end
    logic [SRCS_SYS_BITS-1:0] sys_q;
    logic [WDOG_BITS-1:0] wd_q;
    logic tick;
    logic ovf_q;
    assign tick = &sys_q;
    assign lnk.sys_count = sys_q;
    assign lnk.wdog_ovf = ovf_q;
    always_ff @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_q <= '0;
        end else if (lnk.clear_all) begin
            sys_q <= '0;
        end else if (lnk.service) begin
            sys_q <= {{(SRCS_SYS_BITS-SRCS_SVC_LSB){1'b0}},
                      sys_q[SRCS_SVC_LSB-1:0] + 4'h1};
        end else begin
            sys_q <= sys_q + 13'h0001;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= 1'b0;
            if (lnk.clear_all || lnk.service || !lnk.wdog_en) begin
                wd_q <= '0;
            end else if (tick) begin
                wd_q <= wd_q + 1'b1;
                ovf_q <= &wd_q;
            end
        end
    end
endmodule

// file: src/srcs_clkdiv.sv
`timescale 1ns/1ps
module srcs_clkdiv
    import srcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    srcs_link_if.clk lnk
);
    logic [1:0] div_q;
    assign lnk.bus_clk = div_q[1];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 2'h0;
        end else if (!lnk.run) begin
            div_q <= 2'h0;
        end else if (lnk.src_edge) begin
            div_q <= div_q + 2'h1;
        end
    end
endmodule

// file: src/srcs_sequencer.sv
`timescale 1ns/1ps
module srcs_sequencer
    import srcs_pkg::*;
#(
    parameter int POR_CYCLES = SRCS_POR_CYCLES,
    parameter int PIN_POR_CYCLES = SRCS_PIN_POR_CYCLES,
    parameter int WDOG_BITS = 6,
    parameter logic [15:0] RAM_LO = 16'h0040,
    parameter logic [15:0] RAM_HI = 16'h023F,
    parameter logic [15:0] FLASH_LO = 16'h8000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    input wire logic poweron_pulse_i,
    input wire logic low_voltage_i,
    input wire logic hv_rst_pin_i,
    input wire logic hv_irq_pin_i,
    input wire logic pll_out_clock_i,
    input wire logic monitor_mode_i,
    input wire logic break_state_i,
    input wire logic wait_mode_i,
    input wire logic [15:0] internal_addr_bus_i,
    input wire logic [7:0] internal_data_bus_i,
    input wire logic cpu_write_i,
    input wire logic opcode_fetch_i,
    input wire logic vector_fetch_i,
    input wire logic bad_opcode_i,
    input wire logic stop_exec_i,
    output logic internal_reset_sig_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic internal_bus_clocks_o,
    output logic [15:0] reset_vector_o,
    output logic forced_monitor_entry_o
);
    initial begin
        if (POR_CYCLES < 2 || POR_CYCLES >= 2**SRCS_SEQ_BITS ||
            PIN_POR_CYCLES <= SRCS_PIN_MIN_CYCLES ||
            PIN_POR_CYCLES >= 2**SRCS_SEQ_BITS) begin
            $error("sequencer counts out of range");
        end
    end

    function automatic logic fetch_legal(input logic [15:0] a);
        fetch_legal = (a >= RAM_LO && a <= RAM_HI) || (a >= FLASH_LO);
    endfunction

    localparam logic [12:0] POR_LAST = 13'(POR_CYCLES - 1);
    localparam logic [12:0] DRV_LAST = 13'(SRCS_DRIVE_CYCLES - 1);
    localparam logic [12:0] HOLD_LAST = 13'(SRCS_HOLD_CYCLES - 1);
    localparam logic [12:0] PIN_THR = 13'(SRCS_PIN_MIN_CYCLES);
    localparam logic [12:0] PIN_POR_THR = 13'(PIN_POR_CYCLES);

    srcs_link_if lnk ();
    srcs_counter #(.WDOG_BITS(WDOG_BITS)) u_cnt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .lnk(lnk.cnt)
    );
    srcs_clkdiv u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .lnk(lnk.clk)
    );

    logic [7:0] meta_q;
    logic [7:0] sync_q;
    logic pll_prev_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 8'h01;
            sync_q <= 8'h01;
            pll_prev_q <= 1'b0;
        end else begin
            meta_q <= {break_state_i, monitor_mode_i, pll_out_clock_i,
                       hv_irq_pin_i, hv_rst_pin_i, low_voltage_i,
                       poweron_pulse_i, rst_pin_i};
            sync_q <= meta_q;
            pll_prev_q <= sync_q[5];
        end
    end
    logic pin_low;
    logic por_ev;
    logic lvd_ev;
    logic mon;
    assign pin_low = !sync_q[0];
    assign por_ev = sync_q[1];
    assign lvd_ev = sync_q[2];

    srcs_state_t state_q;
    srcs_state_t state_d;
    logic [12:0] seq_q;
    logic [12:0] pin_cnt_q;
    logic por_origin_q;
    logic vec_hi_erased_q;
    logic mon_forced_q;
    logic [7:0] cause_q;
    logic [7:0] ctrl_q;
    logic [7:0] set_vec;
    logic wdog_ev;
    logic badop_ev;
    logic badadr_ev;
    logic erased_ev;
    logic int_ev;
    logic run;
    assign run = (state_q == ST_RUN);
    assign mon = sync_q[6] || mon_forced_q;

    assign lnk.wdog_en = !((sync_q[6] && (sync_q[3] || sync_q[4])) ||
                           (sync_q[7] && sync_q[3]));
    assign lnk.service = run && cpu_write_i &&
                         internal_addr_bus_i == SRCS_SVC_ADDR;
    assign wdog_ev = run && lnk.wdog_ovf;
    assign badop_ev = run && (bad_opcode_i || stop_exec_i);
    assign badadr_ev = run && opcode_fetch_i &&
                       !fetch_legal(internal_addr_bus_i);
    assign erased_ev = run && vector_fetch_i && vec_hi_erased_q &&
                       internal_addr_bus_i == SRCS_VEC_LO_ADDR &&
                       internal_data_bus_i == SRCS_ERASED;
    assign int_ev = wdog_ev || badop_ev || badadr_ev || erased_ev;
    assign lnk.clear_all = por_ev || lvd_ev || int_ev;
    assign lnk.src_edge = ctrl_q[0] ? (sync_q[5] && !pll_prev_q) : 1'b1;
    assign lnk.run = (state_q != ST_POR);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (int_ev) begin
                    state_d = ST_DRIVE;
                end else if (pin_low) begin
                    state_d = ST_EXT;
                end
            end
            ST_POR: begin
                if (seq_q == POR_LAST) begin
                    state_d = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (seq_q == DRV_LAST) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (seq_q == HOLD_LAST) begin
                    state_d = ST_RUN;
                end
            end
            ST_EXT: begin
                if (!pin_low) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_POR;
        endcase
        if (por_ev || lvd_ev) begin
            state_d = ST_POR;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_POR;
            seq_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q || por_ev || lvd_ev) begin
                seq_q <= '0;
            end else begin
                seq_q <= seq_q + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pin_o <= 1'b0;
            rst_pin_oe_o <= 1'b1;
            internal_reset_sig_o <= 1'b1;
            cpu_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            internal_bus_clocks_o <= 1'b0;
            reset_vector_o <= SRCS_VEC_NORMAL;
        end else begin
            rst_pin_o <= 1'b0;
            rst_pin_oe_o <= (state_d == ST_POR) || (state_d == ST_DRIVE);
            internal_reset_sig_o <= (state_d != ST_RUN);
            cpu_clk_en_o <= (state_d == ST_RUN) && !wait_mode_i;
            periph_clk_en_o <= (state_d != ST_POR);
            internal_bus_clocks_o <= lnk.bus_clk;
            reset_vector_o <= mon ? SRCS_VEC_MONITOR : SRCS_VEC_NORMAL;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vec_hi_erased_q <= 1'b0;
            mon_forced_q <= 1'b0;
            forced_monitor_entry_o <= 1'b0;
        end else begin
            if (vector_fetch_i && internal_addr_bus_i == SRCS_VEC_HI_ADDR)
            begin
                vec_hi_erased_q <= (internal_data_bus_i == SRCS_ERASED);
            end
            if (por_ev) begin
                mon_forced_q <= 1'b0;
            end else if (erased_ev) begin
                mon_forced_q <= 1'b1;
            end
            forced_monitor_entry_o <= por_ev ? 1'b0 :
                                      (erased_ev || mon_forced_q);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_cnt_q <= '0;
            por_origin_q <= 1'b1;
        end else begin
            if (!pin_low) begin
                pin_cnt_q <= '0;
            end else if (pin_cnt_q != 13'h1FFF) begin
                pin_cnt_q <= pin_cnt_q + 13'h0001;
            end
            if (por_ev || lvd_ev) begin
                por_origin_q <= 1'b1;
            end else if (run && !pin_low) begin
                por_origin_q <= 1'b0;
            end
        end
    end

    always_comb begin
        set_vec = 8'h00;
        set_vec[SRCS_F_PIN] = pin_low &&
            (pin_cnt_q == ((por_origin_q ? PIN_POR_THR : PIN_THR) - 13'h1));
        set_vec[SRCS_F_WDOG] = wdog_ev;
        set_vec[SRCS_F_BADOP] = badop_ev;
        set_vec[SRCS_F_BADADR] = badadr_ev;
        set_vec[SRCS_F_MENTRY] = erased_ev;
        set_vec[SRCS_F_LVD] = lvd_ev;
    end

    // Wishbone slave, one wait state
    logic req;
    logic rd_done;
    assign req = wb_cyc_i && wb_stb_i;
    assign rd_done = wb_ack_o && req && !wb_we_i &&
                     wb_adr_i == SRCS_OFS_CAUSE;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o) begin
                unique case (wb_adr_i)
                    SRCS_OFS_CAUSE: wb_dat_o <= {24'h000000, cause_q};
                    SRCS_OFS_CTRL: wb_dat_o <= {24'h000000, ctrl_q};
                    SRCS_OFS_STATUS: wb_dat_o <= {3'h0, lnk.sys_count,
                        11'h000, mon, wait_mode_i, 3'(state_q)};
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    // Control register, bit 0 selects PLL source
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= SRCS_CTRL_RST;
        end else if (wb_ack_o && req && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == SRCS_OFS_CTRL) begin
            ctrl_q <= {7'h00, wb_dat_i[0]};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cause_q <= SRCS_CAUSE_RST;
        end else if (por_ev) begin
            cause_q <= SRCS_CAUSE_RST;
        end else if (rd_done) begin
            cause_q <= (cause_q & ~wb_dat_o[7:0]) | set_vec;
        end else begin
            cause_q <= cause_q | set_vec;
        end
    end

    property p_por_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        state_q == ST_POR |-> rst_pin_oe_o && !periph_clk_en_o;
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("clocks or pin wrong during power-on timeout");

    property p_drive;
        @(posedge clk_i) disable iff (!rst_n_i)
        state_q == ST_DRIVE |-> rst_pin_oe_o && internal_reset_sig_o;
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin not driven in drive phase");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(state_q == ST_HOLD) |->
            (!rst_pin_oe_o && internal_reset_sig_o)[*8];
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold phase shorter than expected");

    property p_vector;
        @(posedge clk_i) disable iff (!rst_n_i)
        mon |=> reset_vector_o == SRCS_VEC_MONITOR;
    endproperty
    a_vector: assert property (p_vector)
        else $error("monitor vector not selected");

    property p_wait;
        @(posedge clk_i) disable iff (!rst_n_i)
        state_d == ST_RUN && wait_mode_i |=> !cpu_clk_en_o && periph_clk_en_o;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait mode clock gating wrong");

    property p_badadr;
        @(posedge clk_i) disable iff (!rst_n_i)
        run && opcode_fetch_i && !fetch_legal(internal_addr_bus_i) &&
            !por_ev && !lvd_ev
            |=> state_q == ST_DRIVE && cause_q[SRCS_F_BADADR];
    endproperty
    a_badadr: assert property (p_badadr)
        else $error("illegal fetch did not reset");

    property p_rdclr;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_done && set_vec == 8'h00 && !por_ev
            |=> (cause_q & $past(wb_dat_o[7:0])) == 8'h00;
    endproperty
    a_rdclr: assert property (p_rdclr)
        else $error("cause read did not clear");

    property p_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        run && stop_exec_i && !por_ev && !lvd_ev
            |=> cause_q[SRCS_F_BADOP] ##1 internal_reset_sig_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not cause opcode reset");
endmodule

// file: tb/srcs_far_model.sv
`timescale 1ns/1ps
module srcs_far_model (
    input wire logic clk_i,
    input wire logic rst_pin_o_i,
    input wire logic rst_pin_oe_i,
    input wire logic ext_low_i,
    output logic pin_level_o,
    output logic pll_out_clock_o
);
    logic [1:0] pll_cnt_q = 2'h0;
    assign pin_level_o = !(ext_low_i || (rst_pin_oe_i && !rst_pin_o_i));
    always @(posedge clk_i) begin
        pll_cnt_q <= pll_cnt_q + 2'h1;
    end
    assign pll_out_clock_o = pll_cnt_q[1];
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import srcs_pkg::*;
    localparam int POR_N = 64;
    typedef struct {int op; logic [15:0] a; logic [7:0] c;
        int drv;} srcs_row_t;
    logic clk_i = 1'b0, rst_n_i = 1'b0, pin_low = 1'b0, saw_rst = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, internal_data_bus_i = 8'hFF;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d, s0;
    logic wb_ack_o, rst_pin_i, rst_pin_o, rst_pin_oe_o, pll_out_clock_i;
    logic poweron_pulse_i = 1'b0, low_voltage_i = 1'b0, hv_rst_pin_i = 1'b0;
    logic hv_irq_pin_i = 1'b0, monitor_mode_i = 1'b0, break_state_i = 1'b0;
    logic wait_mode_i = 1'b0, cpu_write_i = 1'b0, opcode_fetch_i = 1'b0;
    logic vector_fetch_i = 1'b0, bad_opcode_i = 1'b0, stop_exec_i = 1'b0;
    logic [15:0] internal_addr_bus_i = 16'h8000, reset_vector_o;
    logic internal_reset_sig_o, cpu_clk_en_o, periph_clk_en_o;
    logic internal_bus_clocks_o, forced_monitor_entry_o;
    int miscompares = 0, tests_run = 0, cycles = 0, n, i;
    srcs_row_t rows [8] = '{'{0, 16'h8000, 8'h10, 32},
        '{1, 16'h8000, 8'h10, 32}, '{2, 16'h0300, 8'h08, 32},
        '{3, 16'h0300, 8'h00, 0}, '{2, 16'h023F, 8'h00, 0},
        '{5, 16'h8000, 8'h02, POR_N + 32}, '{6, 16'h8000, 8'h80, POR_N + 34},
        '{4, 16'hFFFE, 8'h04, 32}};
    srcs_sequencer #(.POR_CYCLES(POR_N), .PIN_POR_CYCLES(200), .WDOG_BITS(1))
    DUT (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rst_pin_i, .rst_pin_o,
        .rst_pin_oe_o, .poweron_pulse_i, .low_voltage_i, .hv_rst_pin_i,
        .hv_irq_pin_i, .pll_out_clock_i, .monitor_mode_i, .break_state_i,
        .wait_mode_i, .internal_addr_bus_i, .internal_data_bus_i,
        .cpu_write_i, .opcode_fetch_i, .vector_fetch_i, .bad_opcode_i,
        .stop_exec_i, .internal_reset_sig_o, .cpu_clk_en_o, .periph_clk_en_o,
        .internal_bus_clocks_o, .reset_vector_o, .forced_monitor_entry_o);
    srcs_far_model far (.clk_i(clk_i), .rst_pin_o_i(rst_pin_o),
        .rst_pin_oe_i(rst_pin_oe_o), .ext_low_i(pin_low),
        .pin_level_o(rst_pin_i), .pll_out_clock_o(pll_out_clock_i));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (internal_reset_sig_o === 1'b1) saw_rst <= 1'b1;
        if (cycles == 80000) begin
            miscompares++;
            finish_test();
        end
    end
    task finish_test;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge clk_i);
        #1;
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
        wb_adr_i <= a; wb_dat_i <= wd;
        do begin
            tick;
        end while (wb_ack_o !== 1'b1);
        @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    endtask
    task wait_rst(input logic v, input int lim);
        int k;
        k = 0;
        while (internal_reset_sig_o !== v && k < lim) begin tick; k++; end
        chk(internal_reset_sig_o, v);
    endtask
    task count_seq(input int drv);
        n = 0;
        while (rst_pin_oe_o === 1'b1 && n < 500) begin tick; n++; end
        chk(n, drv);
        n = 0;
        while (internal_reset_sig_o === 1'b1 && n < 500) begin tick; n++; end
        chk(n, 32);
    endtask
    task drive(input srcs_row_t r);
        @(posedge clk_i);
        internal_addr_bus_i <= r.a;
        bad_opcode_i <= (r.op == 0 || r.op == 6);
        stop_exec_i <= (r.op == 1);
        poweron_pulse_i <= (r.op == 6);
        opcode_fetch_i <= (r.op == 2); vector_fetch_i <= (r.op == 4);
        low_voltage_i <= (r.op == 5);
        if (r.op == 4) begin
            @(posedge clk_i);
            internal_addr_bus_i <= 16'hFFFF;
        end
        @(posedge clk_i);
        bad_opcode_i <= 1'b0; stop_exec_i <= 1'b0; opcode_fetch_i <= 1'b0;
        vector_fetch_i <= 1'b0; low_voltage_i <= 1'b0;
        poweron_pulse_i <= 1'b0;
        #1;
    endtask
    task period(output int p);
        int k, r;
        logic q;
        r = 0; p = 0; q = internal_bus_clocks_o;
        for (k = 0; k < 100 && r < 2; k++) begin
            tick;
            if (r == 1) p++;
            if (internal_bus_clocks_o === 1'b1 && q === 1'b0) r++;
            q = internal_bus_clocks_o;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        chk(internal_reset_sig_o, 1'b1);
        chk(cpu_clk_en_o, 1'b0);
        chk(rst_pin_i, 1'b0);
        rst_n_i <= 1'b1;
        #1;
        count_seq(POR_N + 32);
        repeat (2) tick;
        chk(cpu_clk_en_o & periph_clk_en_o, 1'b1);
        chk(reset_vector_o, SRCS_VEC_NORMAL);
        wb(1'b0, SRCS_OFS_CAUSE, 0, d);
        chk(d, 32'h80);
        wb(1'b1, SRCS_OFS_CAUSE, 32'hFF, d);
        wb(1'b0, SRCS_OFS_CAUSE, 0, d);
        chk(d, 32'h0);
        wb(1'b0, 8'h0C, 0, d);
        chk(d, 32'h0);
        period(n);
        chk(n, 4);
        wb(1'b1, SRCS_OFS_CTRL, 32'h1, d);
        wb(1'b0, SRCS_OFS_CTRL, 0, d);
        chk(d, 32'h1);
        period(n);
        chk(n, 16);
        wb(1'b1, SRCS_OFS_CTRL, 32'h0, d);
        @(posedge clk_i) wait_mode_i <= 1'b1;
        repeat (4) tick;
        chk({cpu_clk_en_o, periph_clk_en_o}, 2'b01);
        @(posedge clk_i) wait_mode_i <= 1'b0;
        for (i = 0; i < 8; i++) begin
            saw_rst <= 1'b0;
            drive(rows[i]);
            if (rows[i].drv > 0) begin
                wait_rst(1'b1, 10);
                chk(rst_pin_i, 1'b0);
                count_seq(rows[i].drv);
                wb(1'b0, SRCS_OFS_STATUS, 0, d);
                chk(d[28:16] < 13'd160, 1'b1);
            end else begin
                repeat (10) tick;
                chk(saw_rst, 1'b0);
            end
            wb(1'b0, SRCS_OFS_CAUSE, 0, d);
            chk(d, rows[i].c);
        end
        chk(forced_monitor_entry_o, 1'b1);
        wb(1'b0, SRCS_OFS_STATUS, 0, s0);
        foreach (rows[n]) begin
            @(posedge clk_i) pin_low <= 1'b1;
            repeat (n == 0 ? 70 : 20) tick;
            chk(internal_reset_sig_o, 1'b1);
            @(posedge clk_i) pin_low <= 1'b0;
            wait_rst(1'b0, 20);
            wb(1'b0, SRCS_OFS_CAUSE, 0, d);
            chk(d, n == 0 ? 32'h40 : 32'h0);
            if (n == 0) wb(1'b0, SRCS_OFS_STATUS, 0, d);
            if (n == 0) chk((d[28:16] - s0[28:16]) > 13'd70, 1'b1);
            if (n == 1) break;
        end
        saw_rst <= 1'b0;
        for (i = 0; i < 20; i++) begin
            repeat (1000) tick;
            @(posedge clk_i);
            internal_addr_bus_i <= SRCS_SVC_ADDR; cpu_write_i <= 1'b1;
            @(posedge clk_i) cpu_write_i <= 1'b0;
        end
        chk(saw_rst, 1'b0);
        @(posedge clk_i) monitor_mode_i <= 1'b1;
        hv_rst_pin_i <= 1'b1;
        repeat (18000) tick;
        chk(saw_rst, 1'b0);
        @(posedge clk_i) hv_rst_pin_i <= 1'b0;
        wait_rst(1'b1, 18000);
        wait_rst(1'b0, 100);
        chk(reset_vector_o, SRCS_VEC_MONITOR);
        wb(1'b0, SRCS_OFS_CAUSE, 0, d);
        chk(d, 32'h20);
        finish_test();
    end
endmodule
